// ---- logic/iep_pkg.sv ----
// Purpose: Shared constants for the two-wire memory slave pin front end
// Assumes: 25 MHz system clock
// Notes: Device type field and write time are plain defaults
package iep_pkg;
  localparam int unsigned IEP_CLK_HZ = 25000000;
  localparam int unsigned IEP_TWR_US = 10;
  localparam int unsigned IEP_TWR_CYC = (IEP_TWR_US * (IEP_CLK_HZ / 1000000));
  localparam logic [2:0] IEP_TYPE_ARRAY = 3'h5;
  localparam logic [3:0] IEP_TYPE_ID = 4'hb;
  localparam int unsigned IEP_TYPE_LSB = 4;
  localparam int unsigned IEP_CE_BIT = 3;
  localparam logic [3:0] IEP_BIT_LAST = 4'h7;
  localparam logic [3:0] IEP_BIT_ACK = 4'h8;
  localparam logic [1:0] IEP_ADDR_BYTES = 2'h2;
  localparam logic [31:0] IEP_CNT_ONE = 32'h1;

  typedef enum logic [2:0] {
    IEP_ST_STANDBY,
    IEP_ST_DEVSEL,
    IEP_ST_ADDR,
    IEP_ST_DATA,
    IEP_ST_READ,
    IEP_ST_WRITE_CYCLE
  } iep_state_e;
endpackage : iep_pkg

// ---- logic/iep_slave.sv ----
// Purpose: Pin-level front end of a two-wire serial memory slave
// Assumes: SCL and SDA from outside are oversampled by sys_clk_in
// Notes: Array storage and read data are handled by neighbouring blocks
`timescale 1ns/100ps
module iep_slave
  import iep_pkg::*;
#(
  parameter int unsigned TWR_CYCLES = IEP_TWR_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic por_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic chip_select_strap_in,
  input wire logic write_protect_input_in,
  input wire logic [7:0] rd_data_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  output logic wr_strobe_out,
  output logic [17:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  output logic rd_strobe_out,
  output logic busy_out
);

  // Elaboration check: a zero count would leave the write cycle after one cycle, as a count of one does
  if (TWR_CYCLES < 1) begin : g_twr_chk
    $error("TWR_CYCLES must be at least 1");
  end

  logic scl_m_ff, scl_s_ff, scl_d_ff;
  logic sda_m_ff, sda_s_ff, sda_d_ff;
  logic cs_m_ff, cs_s_ff, wp_m_ff, wp_s_ff;
  logic por_m_ff, por_s_ff;
  logic prst;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  iep_state_e state_ff;
  logic [3:0] bit_ff;
  logic [7:0] shift_ff;
  logic [1:0] abytes_ff;
  logic [17:0] addr_ff;
  logic is_read_ff, ack_slot_ff, ack_ok_ff, wr_pend_ff;
  logic [7:0] tx_ff;
  logic pull_low_ff;
  logic [31:0] twr_cnt_ff;

  // Power-on reset: any level asserts at once, release needs two clean cycles
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || por_in) begin
      por_m_ff <= 1'b1;
      por_s_ff <= 1'b1;
    end else begin
      por_m_ff <= 1'b0;
      por_s_ff <= por_m_ff;
    end
  end
  assign prst = rst_in || por_in || por_s_ff;

  always_ff @(posedge sys_clk_in) begin
    scl_m_ff <= scl_in;
    scl_s_ff <= scl_m_ff;
    scl_d_ff <= scl_s_ff;
    sda_m_ff <= sda_in;
    sda_s_ff <= sda_m_ff;
    sda_d_ff <= sda_s_ff;
    cs_m_ff <= chip_select_strap_in;
    cs_s_ff <= cs_m_ff;
    wp_m_ff <= write_protect_input_in;
    wp_s_ff <= wp_m_ff;
  end

  assign scl_rise = scl_s_ff && !scl_d_ff;
  assign scl_fall = !scl_s_ff && scl_d_ff;
  assign start_cond = scl_s_ff && scl_d_ff && !sda_s_ff && sda_d_ff;
  assign stop_cond = scl_s_ff && scl_d_ff && sda_s_ff && !sda_d_ff;

  function automatic logic cs_match(input logic [7:0] sel, input logic strap);
    // Strap is a pin level; the bench resolves a floating pin to 0
    logic type_ok;
    type_ok = (sel[7:5] == IEP_TYPE_ARRAY) || (sel[7:4] == IEP_TYPE_ID);
    cs_match = type_ok && (sel[IEP_CE_BIT] == strap);
  endfunction : cs_match

  // Bit counter and input shift register
  always_ff @(posedge sys_clk_in) begin
    if (prst || start_cond || stop_cond) begin
      bit_ff <= 4'h0;
      shift_ff <= 8'h00;
    end else if (scl_rise && state_ff != IEP_ST_STANDBY && state_ff != IEP_ST_WRITE_CYCLE) begin
      shift_ff <= {shift_ff[6:0], sda_s_ff};
      bit_ff <= (bit_ff == IEP_BIT_ACK) ? 4'h0 : bit_ff + 4'h1;
    end
  end

  // Protocol state machine
  always_ff @(posedge sys_clk_in) begin
    wr_strobe_out <= 1'b0;
    rd_strobe_out <= 1'b0;
    if (prst) begin
      state_ff <= IEP_ST_STANDBY;
      abytes_ff <= 2'h0;
      addr_ff <= 18'h0;
      is_read_ff <= 1'b0;
      ack_slot_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_out <= 18'h0;
      wr_data_out <= 8'h00;
      twr_cnt_ff <= 32'h0;
    end else begin
      case (state_ff)
        IEP_ST_WRITE_CYCLE: begin
          // Bus is deaf here, start conditions included
          if (twr_cnt_ff <= IEP_CNT_ONE) begin
            state_ff <= IEP_ST_STANDBY;
            twr_cnt_ff <= 32'h0;
          end else begin
            twr_cnt_ff <= twr_cnt_ff - IEP_CNT_ONE;
          end
        end
        default: begin
          if (stop_cond) begin
            ack_slot_ff <= 1'b0;
            if (wr_pend_ff) begin
              state_ff <= IEP_ST_WRITE_CYCLE;
              twr_cnt_ff <= TWR_CYCLES;
            end else begin
              state_ff <= IEP_ST_STANDBY;
            end
            wr_pend_ff <= 1'b0;
          end else if (start_cond) begin
            state_ff <= IEP_ST_DEVSEL;
            ack_slot_ff <= 1'b0;
            abytes_ff <= 2'h0;
          end else if (scl_rise && bit_ff == IEP_BIT_LAST) begin
            ack_slot_ff <= 1'b1;
            ack_ok_ff <= 1'b0;
            case (state_ff)
              IEP_ST_DEVSEL: begin
                if (cs_match({shift_ff[6:0], sda_s_ff}, cs_s_ff)) begin
                  ack_ok_ff <= 1'b1;
                  is_read_ff <= sda_s_ff;
                  addr_ff[17:16] <= shift_ff[1:0];
                  state_ff <= sda_s_ff ? IEP_ST_READ : IEP_ST_ADDR;
                  rd_strobe_out <= sda_s_ff;
                end else begin
                  state_ff <= IEP_ST_STANDBY;
                end
              end
              IEP_ST_ADDR: begin
                ack_ok_ff <= 1'b1;
                if (abytes_ff == 2'h0) addr_ff[15:8] <= {shift_ff[6:0], sda_s_ff};
                else addr_ff[7:0] <= {shift_ff[6:0], sda_s_ff};
                abytes_ff <= abytes_ff + 2'h1;
                if (abytes_ff + 2'h1 == IEP_ADDR_BYTES) state_ff <= IEP_ST_DATA;
              end
              IEP_ST_DATA: begin
                if (!wp_s_ff) begin
                  ack_ok_ff <= 1'b1;
                  wr_strobe_out <= 1'b1;
                  wr_addr_out <= addr_ff;
                  wr_data_out <= {shift_ff[6:0], sda_s_ff};
                  wr_pend_ff <= 1'b1;
                  addr_ff[7:0] <= addr_ff[7:0] + 8'h01;
                end else begin
                  ack_ok_ff <= 1'b0;
                end
              end
              default: begin
                ack_ok_ff <= 1'b0;
              end
            endcase
          end else if (scl_rise && bit_ff == IEP_BIT_ACK) begin
            ack_slot_ff <= 1'b0;
            // Slot after our own select ack is not a master answer
            if (state_ff == IEP_ST_READ && !ack_ok_ff) begin
              // Master nack ends the read; ack asks for the next byte
              if (sda_s_ff) state_ff <= IEP_ST_STANDBY;
              else rd_strobe_out <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Output byte loads on the read strobe (last select bit or master ack bit rise), shifts on falling SCL
  always_ff @(posedge sys_clk_in) begin
    if (prst) begin
      tx_ff <= 8'hff;
    end else if (rd_strobe_out) begin
      tx_ff <= rd_data_in;
    end else if (scl_fall && state_ff == IEP_ST_READ && !ack_slot_ff && bit_ff != 4'h0) begin
      tx_ff <= {tx_ff[6:0], 1'b1};
    end
  end

  // Data line driver, updated on falling SCL, released at once in standby or write cycle whatever SCL does
  always_ff @(posedge sys_clk_in) begin
    if (prst) begin
      pull_low_ff <= 1'b0;
    end else if (state_ff == IEP_ST_WRITE_CYCLE || state_ff == IEP_ST_STANDBY) begin
      pull_low_ff <= 1'b0;
    end else if (scl_fall) begin
      if (ack_slot_ff) pull_low_ff <= ack_ok_ff;
      // Shift lands on this same edge, so later bits come from the next position
      else if (state_ff == IEP_ST_READ && bit_ff != IEP_BIT_ACK) begin
        pull_low_ff <= (bit_ff == 4'h0) ? !tx_ff[7] : !tx_ff[6];
      end
      else pull_low_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    sda_out <= 1'b0;
    sda_oe_n_out <= !pull_low_ff;
    busy_out <= (state_ff == IEP_ST_WRITE_CYCLE);
  end

endmodule : iep_slave

// ---- tb/iep_slave_asserts.sv ----
// Purpose: Port assertions for iep_slave
// Assumes: Bound into the dut from tb
// Notes: Write cycle span allows one cycle of slack
`timescale 1ns/100ps
module iep_slave_asserts #(
  parameter int unsigned TWR_CYCLES = 20
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic por_in,
  input wire logic scl_in,
  input wire logic write_protect_input_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic wr_strobe_out,
  input wire logic busy_out
);
  logic [15:0] busy_cnt_ff;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in || por_in);
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !busy_out) begin
      busy_cnt_ff <= 16'h0;
    end else begin
      busy_cnt_ff <= busy_cnt_ff + 16'h1;
    end
  end
  AST_OPEN_DRAIN: assert property (!sda_oe_n_out |-> !sda_out)
    else $error("data driven high");
  AST_POR_QUIET: assert property (disable iff (rst_in)
    por_in [*2] |=> sda_oe_n_out && !wr_strobe_out && !busy_out) else $error("active in por");
  AST_WP_NO_WRITE: assert property (wr_strobe_out |-> !write_protect_input_in)
    else $error("write while protected");
  AST_BUSY_SILENT: assert property (busy_out |-> sda_oe_n_out && !wr_strobe_out)
    else $error("active in write cycle");
  AST_BUSY_SPAN: assert property ($fell(busy_out) |->
    busy_cnt_ff + 1 >= TWR_CYCLES && busy_cnt_ff <= TWR_CYCLES + 1) else $error("busy span");
  AST_STROBE_RISE: assert property (wr_strobe_out |-> $past(scl_in, 2) ##1 !wr_strobe_out)
    else $error("strobe off clock");
  AST_DRIVE_LOW: assert property ($changed(sda_oe_n_out) |-> !$past(scl_in, 3))
    else $error("drive moved with clock high");
  AST_IDLE_FREE: assert property (scl_in [*8] |-> sda_oe_n_out)
    else $error("data held while idle");
endmodule : iep_slave_asserts

// ---- tb/iep_master.sv ----
// Purpose: Two-wire bus master model
// Assumes: Pull-up on the data wire, resolved in tb
// Notes: Data moves 40 ns after clock falls, never with it
`timescale 1ns/100ps
module iep_master (
  output logic scl_out = 1'b1,
  output logic sda_low_out = 1'b0,
  input wire logic sda_in
);
  task automatic bit_clk(input logic low, output logic seen);
    #40;
    sda_low_out = low;
    #120;
    scl_out = 1'b1;
    #150;
    seen = sda_in;
    #10;
    scl_out = 1'b0;
  endtask : bit_clk
  task automatic start_cond();
    sda_low_out = 1'b1;
    #160;
    scl_out = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    #40;
    sda_low_out = 1'b1;
    #120;
    scl_out = 1'b1;
    #160;
    sda_low_out = 1'b0;
    #320;
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_clk(!b[i], s);
    end
    bit_clk(1'b0, s);
    ack = !s;
  endtask : send_byte
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_clk(1'b0, s);
      b[i] = s;
    end
    bit_clk(!nack, s);
  endtask : recv_byte
endmodule : iep_master

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for iep_slave
// Assumes: Floating strap and protect pins driven as 0
// Notes: Write time shortened to 100 cycles
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b0;
  logic strap = 1'b0;
  logic wp = 1'b0;
  logic scl, m_low, sda_oe_n, sda_o, wr_stb, busy, rd_stb;
  logic [17:0] wr_addr, last_addr;
  logic [7:0] wr_data, last_data, acks;
  wire logic sda_w = !(m_low || !sda_oe_n);
  int err_count = 0;
  int n_tests = 0;
  int n_stb = 0;
  int n_rd = 0;
  always #20 clk = !clk;
  always @(posedge clk) begin
    if (rd_stb === 1'b1) n_rd++;
    if (wr_stb === 1'b1) begin
      n_stb++;
      last_addr = wr_addr;
      last_data = wr_data;
    end
  end
  iep_slave #(.TWR_CYCLES(100)) dut (.sys_clk_in(clk), .rst_in(rst), .por_in(por),
    .scl_in(scl), .sda_in(sda_w), .chip_select_strap_in(strap), .write_protect_input_in(wp),
    .rd_data_in(8'ha5), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .wr_strobe_out(wr_stb),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data), .rd_strobe_out(rd_stb), .busy_out(busy));
  iep_master m (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda_w));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic sync();
    @(posedge clk);
    #1;
  endtask : sync
  task automatic frame(input logic [7:0] sel, input logic [31:0] dat, input int n);
    logic a;
    sync();
    m.start_cond();
    m.send_byte(sel, a);
    acks = {7'h0, a};
    for (int i = 0; i < n; i++) begin
      m.send_byte(dat[31 - 8 * i -: 8], a);
      acks = {acks[6:0], a};
    end
    m.stop_cond();
  endtask : frame
  task automatic read_frame();
    logic a;
    logic [7:0] rx;
    sync();
    m.start_cond();
    m.send_byte(8'hab, a);
    m.recv_byte(1'b1, rx);
    m.stop_cond();
    check(a, 1'b1);
    check(rx, 8'ha5);
    check(n_rd, 1);
    check(sda_o, 1'b0);
  endtask : read_frame
  task automatic finish_test();
    $display("errors=%0d checks=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 2; c++) begin
        strap = s[0];
        frame({4'ha, c[0], 3'h0}, 32'h0, 0);
        check(acks, {7'h0, s == c});
      end
    end
    frame(8'haa, 32'h12ff3cc3, 4);
    check(acks, 8'h1f);
    check(n_stb, 2);
    check(last_data, 8'hc3);
    check(last_addr, 18'h11200);
    check(busy, 1'b1);
    frame(8'haa, 32'h0, 0);
    check(acks, 8'h00);
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
    frame(8'haa, 32'h0, 0);
    check(acks, 8'h01);
    wp = 1'b1;
    frame(8'haa, 32'h00405500, 3);
    check(acks, 8'h0e);
    check({n_stb[7:0], busy}, 9'h4);
    wp = 1'b0;
    read_frame();
    por = 1'b1;
    frame(8'haa, 32'h0, 0);
    check({acks, sda_oe_n}, 9'h1);
    por = 1'b0;
    repeat (4) @(posedge clk);
    frame(8'haa, 32'h0, 0);
    check(acks, 8'h01);
    finish_test();
  end
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule : tb
bind iep_slave iep_slave_asserts #(.TWR_CYCLES(TWR_CYCLES)) chk (.*);
